// ==== hw/dhp_ctrl.sv ====
// Downstream hot-plug controller: per-port slot logic, events and signalling
// Behaviour
// - One controller per port, active if capable
// - Slot signals exchanged via expander-side ports
// - Presence from pin and/or link, selectable
// - Per-signal invert bit, shared by all ports
// - Interlock command pulses output 100-150 ms
// - Toggle mode inverts interlock per command
// - Latch input reported as interlock status
// - Latch state reads closed in that mode
// - Otherwise interlock status mirrors interlock output
// - Latch open cuts power when configured
// - Power fault status not latched, follows level; its event is sticky
// - Command completed set only by commands
// - Interrupts only while hot-plug interrupt enable set
// - Unmasked slot events raise an interrupt
// - MSI if enabled, else INTx unless disabled
// - D3hot, interrupts off: wakeup message only
// - D3hot, interrupts on: both; masked: none
// - Command completed never causes wakeup
// - General event mode replaces all messaging
// - Event reaches GPIO pin only if alternate
// - General event sets port status bit
module dhp_ctrl #(
    parameter int unsigned NUM_PORTS  = 3,
    parameter int unsigned PULSE_CYC  = dhp_pkg::ILOCK_PULSE_CYC
) (
    input  wire logic                                 clock,
    input  wire logic                                 reset,
    input  wire logic [7:0]                           regAddr,
    input  wire logic [31:0]                          regWdata,
    input  wire logic                                 regWrite,
    input  wire logic                                 regRead,
    output logic [31:0]                               regRdata,
    input  wire dhp_pkg::dhp_slot_in_t [NUM_PORTS-1:0] slotIn,
    input  wire logic [NUM_PORTS-1:0]                 linkPresence,
    output logic [NUM_PORTS*4-1:0]                    slotOut,
    output logic [NUM_PORTS-1:0]                      msiReq,
    output logic [NUM_PORTS-1:0]                      intxAssert,
    output logic [NUM_PORTS-1:0]                      pmeReq,
    output logic                                      generalEventOut,
    output logic                                      gpio7Out
);

    // ------------------------------------------------------------------
    // Global registers
    // ------------------------------------------------------------------
    logic [dhp_pkg::CFG_W-1:0] config_r;
    logic [NUM_PORTS-1:0]      gevCtl_r;
    logic [NUM_PORTS-1:0]      gevSts_r;
    logic                      gpioAlt_r;
    logic                      genEvt_r;
    logic                      gpio7_r;
    logic [31:0]               rdata_r;
    wire  [NUM_PORTS-1:0]      gevSet;
    wire  [NUM_PORTS-1:0][31:0] capWord;
    wire  [NUM_PORTS-1:0][31:0] ctlWord;
    wire  [NUM_PORTS-1:0][31:0] stsWord;
    wire  [NUM_PORTS-1:0][31:0] pmWord;

    wire logic [4:0] inInv  = config_r[dhp_pkg::CFG_IN_INV_LSB +: 5];
    wire logic [3:0] outInv = config_r[dhp_pkg::CFG_OUT_INV_LSB +: 4];
    wire logic toggleMode   = config_r[dhp_pkg::CFG_TOGGLE];
    wire logic latchAsIl    = config_r[dhp_pkg::CFG_LATCH_AS_IL];
    wire logic autoOff      = config_r[dhp_pkg::CFG_AUTO_OFF];
    wire logic pinPres      = config_r[dhp_pkg::CFG_PIN_PRES];
    wire logic inbandPres   = config_r[dhp_pkg::CFG_INBAND_PRES];
    wire logic switchD3     = config_r[dhp_pkg::CFG_SWITCH_D3];

    // Global configuration, general event control and pin mux writes
    always_ff @(posedge clock) begin
        if (reset) begin
            config_r  <= dhp_pkg::CFG_RST;
            gevCtl_r  <= '0;
            gpioAlt_r <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == dhp_pkg::HP_CONFIG_OFS) begin
                config_r <= regWdata[dhp_pkg::CFG_W-1:0];
            end
            if (regAddr == dhp_pkg::GEN_EVT_CTL_OFS) begin
                gevCtl_r <= regWdata[NUM_PORTS-1:0];
            end
            if (regAddr == dhp_pkg::GPIO_ALT_OFS) begin
                gpioAlt_r <= regWdata[0];
            end
        end
    end

    // General event status: write one to clear, a new event wins the race
    always_ff @(posedge clock) begin
        if (reset) begin
            gevSts_r <= '0;
        end else if (regWrite && regAddr == dhp_pkg::GEN_EVT_STS_OFS) begin
            gevSts_r <= (gevSts_r & ~regWdata[NUM_PORTS-1:0]) | gevSet;
        end else begin
            gevSts_r <= gevSts_r | gevSet;
        end
    end

    // Event output stays up while any port has an unacknowledged event
    always_ff @(posedge clock) begin
        if (reset) begin
            genEvt_r <= 1'b0;
            gpio7_r  <= 1'b0;
        end else begin
            genEvt_r <= |(gevSts_r | gevSet);
            gpio7_r  <= gpioAlt_r & (|(gevSts_r | gevSet));
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Data stands only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= '0;
            if (regRead) begin
                unique case (regAddr)
                    dhp_pkg::HP_CONFIG_OFS:   rdata_r <= 32'(config_r);
                    dhp_pkg::GEN_EVT_CTL_OFS: rdata_r <= 32'(gevCtl_r);
                    dhp_pkg::GEN_EVT_STS_OFS: rdata_r <= 32'(gevSts_r);
                    dhp_pkg::GPIO_ALT_OFS:    rdata_r <= 32'(gpioAlt_r);
                    default: begin
                        for (int i = 0; i < NUM_PORTS; i++) begin
                            case (regAddr - 8'(dhp_pkg::PORT_BASE + i * dhp_pkg::PORT_STRIDE))
                                dhp_pkg::SLOT_CAP_OFS: rdata_r <= capWord[i];
                                dhp_pkg::SLOT_CTL_OFS: rdata_r <= ctlWord[i];
                                dhp_pkg::SLOT_STS_OFS: rdata_r <= stsWord[i];
                                dhp_pkg::PORT_PM_OFS:  rdata_r <= pmWord[i];
                                default: ;
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-port hot-plug controller
    // ------------------------------------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        localparam logic [7:0] BASE = 8'(dhp_pkg::PORT_BASE + p * dhp_pkg::PORT_STRIDE);

        logic [dhp_pkg::CAP_W-1:0] cap_r;
        logic [dhp_pkg::CTL_W-1:0] ctl_r;
        logic [dhp_pkg::PM_W-1:0]  pm_r;
        logic [dhp_pkg::EVT_W-1:0] evt_r;
        logic [4:0]                meta_r;
        logic [4:0]                sync_r;
        dhp_pkg::dhp_slot_in_t     prev_r;
        logic                      presPrev_r;
        logic                      cmdDone_r;
        logic                      ilock_r;
        logic [dhp_pkg::ILOCK_CNT_W-1:0] ilockCnt_r;
        logic [3:0]                out_r;
        logic                      msi_r;
        logic                      intx_r;
        logic                      pme_r;

        dhp_pkg::dhp_slot_in_t     sense;
        logic                      hpc;
        logic                      presNow;
        logic                      wrCap;
        logic                      wrCtl;
        logic                      wrSts;
        logic                      wrPm;
        logic [dhp_pkg::EVT_W-1:0] evtSet;
        logic [dhp_pkg::EVT_W-1:0] evtNew;
        logic                      inD3;
        logic                      gevMode;
        logic                      hpie;
        logic                      pwrAllowed;

        // Access decode and polarity-corrected slot sensor view
        assign wrCap   = regWrite && regAddr == BASE + dhp_pkg::SLOT_CAP_OFS;
        assign wrCtl   = regWrite && regAddr == BASE + dhp_pkg::SLOT_CTL_OFS;
        assign wrSts   = regWrite && regAddr == BASE + dhp_pkg::SLOT_STS_OFS;
        assign wrPm    = regWrite && regAddr == BASE + dhp_pkg::PORT_PM_OFS;
        assign sense   = dhp_pkg::dhp_slot_in_t'(sync_r ^ inInv);
        assign hpc     = cap_r[dhp_pkg::CAP_HP_CAPABLE];
        assign presNow = (pinPres & sense.presence) | (inbandPres & linkPresence[p]);
        assign hpie    = ctl_r[dhp_pkg::CTL_HPIE];
        assign gevMode = gevCtl_r[p];
        assign inD3    = pm_r[dhp_pkg::PM_PORT_D3] | switchD3;

        // Expander inputs are foreign to this clock: two flops first
        always_ff @(posedge clock) begin
            if (reset) begin
                meta_r <= '0;
                sync_r <= '0;
            end else begin
                meta_r <= slotIn[p];
                sync_r <= meta_r;
            end
        end

        // Capabilities, slot control and interrupt mode registers
        always_ff @(posedge clock) begin
            if (reset) begin
                cap_r <= dhp_pkg::CAP_RST;
                ctl_r <= dhp_pkg::CTL_RST;
                pm_r  <= dhp_pkg::PM_RST;
            end else begin
                if (wrCap) begin
                    cap_r <= regWdata[dhp_pkg::CAP_W-1:0];
                end
                if (wrCtl) begin
                    ctl_r <= regWdata[dhp_pkg::CTL_W-1:0];
                end
                if (wrPm) begin
                    pm_r <= regWdata[dhp_pkg::PM_W-1:0];
                end
            end
        end

        // Edge history for change detection
        always_ff @(posedge clock) begin
            if (reset) begin
                prev_r     <= '0;
                presPrev_r <= 1'b0;
                cmdDone_r  <= 1'b0;
            end else begin
                prev_r     <= sense;
                presPrev_r <= presNow;
                cmdDone_r  <= wrCtl & hpc;
            end
        end

        // Latch changes are not events while the latch stands in for the interlock
        always_comb begin
            evtSet = '0;
            if (hpc) begin
                evtSet[dhp_pkg::EVT_BUTTON]   = sense.button & ~prev_r.button;
                evtSet[dhp_pkg::EVT_FAULT]    = sense.powerFault & ~prev_r.powerFault;
                evtSet[dhp_pkg::EVT_LATCH]    = ~latchAsIl & (sense.latchOpen ^ prev_r.latchOpen);
                evtSet[dhp_pkg::EVT_PRESENCE] = presNow ^ presPrev_r;
                evtSet[dhp_pkg::EVT_CMD_DONE] = cmdDone_r;
            end
        end
        assign evtNew = evtSet & ctl_r[dhp_pkg::EVT_W-1:0];

        // Sticky slot events, write one to clear, set beats clear
        always_ff @(posedge clock) begin
            if (reset) begin
                evt_r <= '0;
            end else if (wrSts) begin
                evt_r <= (evt_r & ~regWdata[dhp_pkg::EVT_W-1:0]) | evtSet;
            end else begin
                evt_r <= evt_r | evtSet;
            end
        end

        // Interlock: timed pulse, or level flip in toggle mode
        always_ff @(posedge clock) begin
            if (reset) begin
                ilock_r    <= 1'b0;
                ilockCnt_r <= '0;
            end else if (wrCtl && hpc && regWdata[dhp_pkg::CTL_ILOCK_CMD]) begin
                if (toggleMode) begin
                    ilock_r <= ~ilock_r;
                end else begin
                    ilock_r    <= 1'b1;
                    ilockCnt_r <= dhp_pkg::ILOCK_CNT_W'(PULSE_CYC);
                end
            end else if (ilockCnt_r != '0) begin
                ilockCnt_r <= ilockCnt_r - 1'b1;
                if (ilockCnt_r == dhp_pkg::ILOCK_CNT_W'(1)) begin
                    ilock_r <= 1'b0;
                end
            end
        end

        // Open latch overrides the power command when both options allow it
        assign pwrAllowed = ~(autoOff & cap_r[dhp_pkg::CAP_LATCH_PRES] & sense.latchOpen);

        // Slot outputs toward the expander, polarity applied last
        always_ff @(posedge clock) begin
            if (reset) begin
                out_r <= '0;
            end else begin
                out_r <= outInv ^ ({4{hpc}} & {ilock_r,
                                               ctl_r[dhp_pkg::CTL_PWR_ON] & pwrAllowed,
                                               ctl_r[dhp_pkg::CTL_PWR_IND],
                                               ctl_r[dhp_pkg::CTL_ATTN_IND]});
            end
        end

        // Event signalling: general event mode suppresses every message
        always_ff @(posedge clock) begin
            if (reset) begin
                msi_r  <= 1'b0;
                intx_r <= 1'b0;
                pme_r  <= 1'b0;
            end else begin
                msi_r  <= ~gevMode & hpie & pm_r[dhp_pkg::PM_MSI_EN] & (|evtNew);
                intx_r <= ~gevMode & hpie & ~pm_r[dhp_pkg::PM_MSI_EN]
                          & ~pm_r[dhp_pkg::PM_INTX_DIS] & (|(evt_r & ctl_r[dhp_pkg::EVT_W-1:0]));
                pme_r  <= ~gevMode & inD3 & (|evtNew[dhp_pkg::EVT_PRESENCE:0]);
            end
        end
        assign gevSet[p] = gevMode & (|evtNew);

        // Register views for the read path
        assign capWord[p] = 32'(cap_r);
        assign ctlWord[p] = 32'(ctl_r);
        assign stsWord[p] = {22'h000000,
                             sense.powerGood,
                             sense.powerFault,
                             latchAsIl ? sense.latchOpen : ilock_r,
                             presNow,
                             latchAsIl ? 1'b0 : sense.latchOpen,
                             evt_r};
        assign pmWord[p]  = 32'(pm_r);

        assign slotOut[p*4 +: 4] = out_r;
        assign msiReq[p]         = msi_r;
        assign intxAssert[p]     = intx_r;
        assign pmeReq[p]         = pme_r;
    end

    assign regRdata        = rdata_r;
    assign generalEventOut = genEvt_r;
    assign gpio7Out        = gpio7_r;

endmodule

// ==== hw/dhp_pkg.sv ====
// Package of constants and types for the downstream hot-plug controller
package dhp_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_KHZ        = 40000;
    localparam int unsigned ILOCK_MIN_MS     = 100;
    localparam int unsigned ILOCK_MAX_MS     = 150;
    localparam int unsigned ILOCK_PULSE_MS   = (ILOCK_MIN_MS + ILOCK_MAX_MS) / 2;
    localparam int unsigned ILOCK_PULSE_CYC  = ILOCK_PULSE_MS * CLOCK_KHZ;
    localparam int unsigned ILOCK_CNT_W      = 23;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] HP_CONFIG_OFS     = 8'h00;
    localparam logic [7:0] GEN_EVT_CTL_OFS   = 8'h04;
    localparam logic [7:0] GEN_EVT_STS_OFS   = 8'h08;
    localparam logic [7:0] GPIO_ALT_OFS      = 8'h0C;
    localparam int unsigned PORT_BASE        = 16;
    localparam int unsigned PORT_STRIDE      = 16;
    localparam logic [7:0] SLOT_CAP_OFS      = 8'h00;
    localparam logic [7:0] SLOT_CTL_OFS      = 8'h04;
    localparam logic [7:0] SLOT_STS_OFS      = 8'h08;
    localparam logic [7:0] PORT_PM_OFS       = 8'h0C;
    localparam int unsigned FIRST_PORT_NUM   = 2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // Config: [4:0] input invert, [8:5] output invert, then mode bits
    localparam int unsigned CFG_IN_INV_LSB   = 0;
    localparam int unsigned CFG_OUT_INV_LSB  = 5;
    localparam int unsigned CFG_TOGGLE       = 9;
    localparam int unsigned CFG_LATCH_AS_IL  = 10;
    localparam int unsigned CFG_AUTO_OFF     = 11;
    localparam int unsigned CFG_PIN_PRES     = 12;
    localparam int unsigned CFG_INBAND_PRES  = 13;
    localparam int unsigned CFG_SWITCH_D3    = 14;
    localparam int unsigned CFG_W            = 15;
    // Slot capabilities
    localparam int unsigned CAP_HP_CAPABLE   = 0;
    localparam int unsigned CAP_LATCH_PRES   = 1;
    localparam int unsigned CAP_W            = 2;
    // Slot control: [4:0] event enables, same order as event bits
    localparam int unsigned CTL_HPIE         = 5;
    localparam int unsigned CTL_ATTN_IND     = 6;
    localparam int unsigned CTL_PWR_IND      = 7;
    localparam int unsigned CTL_PWR_ON       = 8;
    localparam int unsigned CTL_ILOCK_CMD    = 9;
    localparam int unsigned CTL_W            = 9;
    // Slot status events
    localparam int unsigned EVT_BUTTON       = 0;
    localparam int unsigned EVT_FAULT        = 1;
    localparam int unsigned EVT_LATCH        = 2;
    localparam int unsigned EVT_PRESENCE     = 3;
    localparam int unsigned EVT_CMD_DONE     = 4;
    localparam int unsigned EVT_W            = 5;
    // Port power management / interrupt mode
    localparam int unsigned PM_MSI_EN        = 0;
    localparam int unsigned PM_INTX_DIS      = 1;
    localparam int unsigned PM_PORT_D3       = 2;
    localparam int unsigned PM_W             = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CFG_W-1:0] CFG_RST     = 15'h1000;
    localparam logic [CAP_W-1:0] CAP_RST     = 2'h0;
    localparam logic [CTL_W-1:0] CTL_RST     = 9'h000;
    localparam logic [PM_W-1:0]  PM_RST      = 3'h0;

    // ------------------------------------------------------------------
    // Slot signal carriers (asserted-true after polarity handling)
    // ------------------------------------------------------------------
    typedef struct packed {
        logic powerGood;
        logic latchOpen;
        logic powerFault;
        logic presence;
        logic button;
    } dhp_slot_in_t;

    typedef struct packed {
        logic interlock;
        logic powerEnable;
        logic powerIndicator;
        logic attentionIndicator;
    } dhp_slot_out_t;

endpackage

// ==== tb/dhp_ctrl_monitor.sv ====
// Checker: port-level rules of the hot-plug controller
module dhp_ctrl_monitor #(
    parameter int unsigned NUM_PORTS = 3,
    parameter int unsigned PULSE_CYC = 20
) (
    input wire logic                                  clock,
    input wire logic                                  reset,
    input wire logic [7:0]                            regAddr,
    input wire logic [31:0]                           regWdata,
    input wire logic                                  regWrite,
    input wire dhp_pkg::dhp_slot_in_t [NUM_PORTS-1:0] slotIn,
    input wire logic [NUM_PORTS*4-1:0]                slotOut,
    input wire logic [NUM_PORTS-1:0]                  msiReq,
    input wire logic [NUM_PORTS-1:0]                  intxAssert,
    input wire logic [NUM_PORTS-1:0]                  pmeReq,
    input wire logic                                  generalEventOut,
    input wire logic                                  gpio7Out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TAIL = PULSE_CYC - 7;
    logic [14:0] cfg_r;
    logic [1:0]  cap_r;
    logic [8:0]  ctl_r;
    logic [2:0]  pm_r;
    wire         ilockCmd = regWrite && regAddr == 8'h14 && regWdata[9] && cap_r[0];
    // Shadow of the config and port 0 registers, updated by writes
    always_ff @(posedge clock) begin
        if (reset) begin
            cfg_r <= dhp_pkg::CFG_RST;
            cap_r <= 2'h0;
            ctl_r <= 9'h000;
            pm_r  <= 3'h0;
        end else if (regWrite) begin
            case (regAddr)
                8'h00: cfg_r <= regWdata[14:0];
                8'h10: cap_r <= regWdata[1:0];
                8'h14: ctl_r <= regWdata[8:0];
                8'h1C: pm_r <= regWdata[2:0];
                default: ;
            endcase
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (reset);
    sequence ilockHigh; slotOut[3] [*8]; endsequence
    sequence latchOpenHeld; (cfg_r[11] && cap_r == 2'h3 && (slotIn[0].latchOpen ^ cfg_r[3])) [*6]; endsequence
    pulse_len_a: assert property (ilockCmd && !cfg_r[9] && !cfg_r[8] |=> ##1 ilockHigh ##TAIL !slotOut[3])
        else $error("interlock pulse length wrong");
    toggle_flip_a: assert property (ilockCmd && cfg_r[9] |-> ##2 slotOut[3] != $past(slotOut[3], 2))
        else $error("interlock did not toggle");
    auto_off_a: assert property (latchOpenHeld |-> slotOut[2] == cfg_r[7])
        else $error("power stays on with latch open");
    no_hpie_a: assert property ((!ctl_r[5]) [*3] |-> !msiReq[0] && !intxAssert[0])
        else $error("interrupt without enable");
    intx_mode_a: assert property ((pm_r[0] || pm_r[1]) [*3] |-> !intxAssert[0])
        else $error("intx while msi on or intx off");
    wake_d3_a: assert property (pmeReq[0] |-> pm_r[2] || cfg_r[14] || $past(pm_r[2] || cfg_r[14]))
        else $error("wakeup outside d3");
    cc_wake_a: assert property ((ctl_r[4:0] == 5'h10) [*4] |-> !pmeReq[0])
        else $error("wakeup from command done");
    gpio_gate_a: assert property (gpio7Out |-> generalEventOut || $past(generalEventOut))
        else $error("gpio without general event");
    idle_out_a: assert property ((!cap_r[0] && $stable(cfg_r)) [*3] |-> slotOut[3:0] == cfg_r[8:5])
        else $error("incapable port drives outputs");
endmodule
bind dhp_ctrl dhp_ctrl_monitor #(.NUM_PORTS(NUM_PORTS), .PULSE_CYC(PULSE_CYC)) dhp_ctrl_monitor_inst (
    .clock(clock), .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .slotIn(slotIn),
    .slotOut(slotOut), .msiReq(msiReq), .intxAssert(intxAssert), .pmeReq(pmeReq),
    .generalEventOut(generalEventOut), .gpio7Out(gpio7Out));

// ==== tb/dhp_slot_model.sv ====
// Slot partner: card sensors and board power logic
module dhp_slot_model (
    input wire logic              clock,
    input wire logic              powerEnable,
    input wire logic              cardIn,
    input wire logic              latchOpen,
    input wire logic              button,
    input wire logic              faultHit,
    output dhp_pkg::dhp_slot_in_t slotLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic faultHeld = 1'b0;
    logic pgR       = 1'b0;
    logic enPrev    = 1'b0;
    // Board holds a fault until power enable toggles, so a glitch is seen
    always @(posedge clock) begin
        enPrev <= powerEnable;
        pgR <= powerEnable & cardIn;
        if (faultHit)
            faultHeld <= 1'b1;
        else if (enPrev != powerEnable)
            faultHeld <= 1'b0;
    end
    assign slotLine = {pgR, latchOpen, faultHeld, cardIn, button};
endmodule

// ==== tb/dhp_ctrl_tb.sv ====
// Testbench of the hot-plug controller
module dhp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clock = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, linkUp = 1'b0;
    logic [7:0]            regAddr = 8'h00;
    logic [31:0]           regWdata = 32'h0, regRdata, rnd = 32'h83BB;
    dhp_pkg::dhp_slot_in_t slotLine;
    logic [11:0]           slotOut;
    logic [2:0]            msiReq, intxAssert, pmeReq;
    logic                  generalEventOut, gpio7Out, cardIn = 0, latchOpen = 0, button = 0, faultHit = 0;
    int                    errorCnt = 0, nCompared = 0, cycles = 0, msiCnt = 0, pmeCnt = 0, m0, p0;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    dhp_ctrl #(.NUM_PORTS(3), .PULSE_CYC(20)) dhp_ctrl_inst (.clock(clock), .reset(reset), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .slotIn({rnd[9:0], slotLine}), .linkPresence({rnd[11:10], linkUp}), .slotOut(slotOut), .msiReq(msiReq),
        .intxAssert(intxAssert), .pmeReq(pmeReq), .generalEventOut(generalEventOut), .gpio7Out(gpio7Out));
    dhp_slot_model dhp_slot_model_inst (.clock(clock), .powerEnable(slotOut[2]), .cardIn(cardIn),
        .latchOpen(latchOpen), .button(button), .faultHit(faultHit), .slotLine(slotLine));
    initial forever #12.5 clock = ~clock;
    // Random idle-port sensors, pulse counts, hang limit
    always @(posedge clock) begin
        rnd <= xs(rnd);
        msiCnt <= msiCnt + int'(msiReq[0] === 1'b1);
        pmeCnt <= pmeCnt + int'(pmeReq[0] === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errorCnt++;
            completeRun();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        nCompared++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    // Read data stand one cycle only: sample just after that edge
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1 chk(regRdata & m, e, nm);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic press(input logic [31:0] c);
        p0 = pmeCnt;
        button <= 1'b0;
        wr(8'h14, c);
        tick(4);
        button <= 1'b1;
        tick(6);
    endtask
    task automatic completeRun();
        $display("compared %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Scenarios; each prints one line when it ends
    initial begin
        tick(6);
        reset <= 1'b0;
        rd(8'h10, 32'hFFFFFFFF, 32'h0, "cap");
        rd(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
        wr(8'h10, 32'h3);
        wr(8'h14, 32'h3F);
        tick(4);
        chk(intxAssert, 32'h1, "intx");
        rd(8'h18, 32'h1F, 32'h10, "cmdDone");
        wr(8'h1C, 32'h1);
        wr(8'h18, 32'h1F);
        m0 = msiCnt;
        wr(8'h14, 32'h3F);
        tick(4);
        chk(msiCnt - m0, 32'h1, "msi");
        chk(intxAssert, 32'h0, "intxOff");
        $display("test irq done");
        wr(8'h14, 32'h23F);
        tick(2);
        chk(slotOut[3], 32'h1, "pulse");
        tick(20);
        chk(slotOut[3], 32'h0, "pulseEnd");
        wr(8'h00, 32'h1200);
        wr(8'h14, 32'h23F);
        tick(25);
        chk(slotOut[3], 32'h1, "toggle");
        rd(8'h18, 32'h80, 32'h80, "ilockSts");
        wr(8'h14, 32'h23F);
        tick(2);
        chk(slotOut[3], 32'h0, "toggleBack");
        $display("test interlock done");
        cardIn <= 1'b1;
        tick(6);
        rd(8'h18, 32'h48, 32'h48, "presence");
        wr(8'h00, 32'h2000);
        rd(8'h18, 32'h40, 32'h0, "inband");
        linkUp <= 1'b1;
        tick(4);
        rd(8'h18, 32'h40, 32'h40, "inbandUp");
        wr(8'h00, 32'h1020);
        tick(2);
        chk(slotOut, 12'h111, "invert");
        wr(8'h00, 32'h1400);
        latchOpen <= 1'b1;
        tick(6);
        rd(8'h18, 32'hA0, 32'h80, "latchIl");
        wr(8'h00, 32'h1800);
        wr(8'h14, 32'h13F);
        tick(6);
        chk(slotOut[2], 32'h0, "autoOff");
        latchOpen <= 1'b0;
        tick(6);
        chk(slotOut[2], 32'h1, "powerOn");
        $display("test slot done");
        faultHit <= 1'b1;
        tick(1);
        faultHit <= 1'b0;
        tick(6);
        rd(8'h18, 32'h102, 32'h102, "fault");
        wr(8'h14, 32'h3F);
        tick(6);
        rd(8'h18, 32'h100, 32'h0, "faultLive");
        wr(8'h1C, 32'h4);
        wr(8'h18, 32'h1F);
        press(32'h1F);
        chk(pmeCnt - p0, 32'h1, "wake");
        chk(intxAssert, 32'h0, "noIrq");
        press(32'h3F);
        chk(pmeCnt - p0, 32'h1, "wakeIrq");
        chk(intxAssert, 32'h1, "irq");
        press(32'h30);
        chk(pmeCnt - p0, 32'h0, "masked");
        $display("test wake done");
        wr(8'h1C, 32'h0);
        wr(8'h0C, 32'h1);
        wr(8'h04, 32'h1);
        wr(8'h18, 32'h1F);
        wr(8'h14, 32'h3F);
        tick(4);
        chk({generalEventOut, gpio7Out, intxAssert}, 32'h18, "gpe");
        rd(8'h08, 32'h7, 32'h1, "gpeSts");
        wr(8'h0C, 32'h0);
        tick(2);
        chk({generalEventOut, gpio7Out}, 32'h2, "gpioOff");
        $display("test general event done");
        completeRun();
    end
endmodule
